//--- logic/pin_sync.sv
module pin_sync
  import rtcc_read_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // ------------------------------------------------------------
  // two-stage synchroniser, idle bus level is high
  // ------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // refused while elaborating, so a bad width never reaches a run
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs WIDTH of at least 1");
  end

  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (i_clk_en) begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule : pin_sync

//--- logic/rtcc_read_pkg.sv
package rtcc_read_pkg;
  // ------------------------------------------------------------
  // bus addressing
  // ------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h6f;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  // ------------------------------------------------------------
  // memory map
  // ------------------------------------------------------------
  localparam int PTR_W = 7;
  localparam logic [PTR_W-1:0] TK_FIRST = 7'h00;
  localparam logic [PTR_W-1:0] TK_LAST = 7'h1f;
  localparam logic [PTR_W-1:0] RAM_FIRST = 7'h20;
  localparam logic [PTR_W-1:0] RAM_LAST = 7'h5f;
  localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
  // ------------------------------------------------------------
  // byte framing
  // ------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST_SHIFT = 4'h7;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {KIND_CTRL, KIND_ADDR, KIND_WDATA} byte_kind_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RX_BYTE, ST_ACK_DRV, ST_TX_BYTE, ST_ACK_SMP} link_state_t;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    if (p == TK_LAST) begin
      next_ptr = TK_FIRST;
    end else if (p == RAM_LAST) begin
      next_ptr = RAM_FIRST;
    end else begin
      next_ptr = p + 7'h01;
    end
  endfunction : next_ptr
endpackage : rtcc_read_pkg

//--- logic/rtcc_read_target.sv
module rtcc_read_target
  import rtcc_read_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_on_backup,
  output logic [PTR_W-1:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  // ------------------------------------------------------------
  // pin sampling and bus events
  // ------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_q_r;
  logic scl_q_nxt;
  logic sda_q_r;
  logic sda_q_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;

  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_async({i_scl, i_sda_in}),
    .o_sync({scl_s, sda_s})
  );

  always_comb begin
    scl_q_nxt = i_clk_en ? scl_s : scl_q_r;
    sda_q_nxt = i_clk_en ? sda_s : sda_q_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
    end
  end

  assign scl_rise = i_clk_en && scl_s && !scl_q_r;
  assign scl_fall = i_clk_en && !scl_s && scl_q_r;
  // data moving while the clock is high marks start or stop
  assign start_evt = i_clk_en && scl_s && scl_q_r && sda_q_r && !sda_s;
  assign stop_evt = i_clk_en && scl_s && scl_q_r && !sda_q_r && sda_s;

  // ------------------------------------------------------------
  // link state machine
  // ------------------------------------------------------------
  link_state_t state_r;
  link_state_t state_nxt;
  byte_kind_t kind_r;
  byte_kind_t kind_nxt;
  logic [3:0] bitcnt_r;
  logic [3:0] bitcnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic read_r;
  logic read_nxt;
  logic mack_r;
  logic mack_nxt;
  logic [PTR_W-1:0] ptr_r;
  logic [PTR_W-1:0] ptr_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic byte_done;
  logic ptr_adv;
  logic accept;

  assign byte_done = (state_r == ST_RX_BYTE) && scl_fall && (bitcnt_r == BITS_PER_BYTE);
  assign ptr_adv = (state_r == ST_TX_BYTE) && scl_fall && (bitcnt_r == TX_LAST_SHIFT);

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    read_nxt = read_r;
    mack_nxt = mack_r;
    ptr_nxt = ptr_r;
    oe_n_nxt = oe_n_r;
    accept = 1'b0;
    if (stop_evt) begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else if (start_evt) begin
      // a repeated start closes a write but leaves the pointer alone
      state_nxt = ST_RX_BYTE;
      kind_nxt = KIND_CTRL;
      bitcnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        ST_RX_BYTE: begin
          if (scl_rise && bitcnt_r != BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end else if (byte_done) begin
            unique case (kind_r)
              KIND_CTRL: begin
                accept = (shift_r[7:1] == DEV_ADDR) && !i_on_backup;
                read_nxt = shift_r[0] == RW_READ;
              end
              KIND_ADDR: begin
                // an address past the memory is refused, pointer untouched
                accept = (shift_r <= {1'b0, RAM_LAST}) && !i_on_backup;
                if (accept) begin
                  ptr_nxt = shift_r[PTR_W-1:0];
                end
              end
              KIND_WDATA: begin
                // write data belongs to the write path; acked, not stored here
                accept = !i_on_backup;
              end
              default: begin
                accept = 1'b0;
              end
            endcase
            state_nxt = accept ? ST_ACK_DRV : ST_IDLE;
            oe_n_nxt = !accept;
          end
        end
        ST_ACK_DRV: begin
          if (scl_fall) begin
            bitcnt_nxt = 4'h0;
            if (kind_r == KIND_CTRL && read_r) begin
              state_nxt = ST_TX_BYTE;
              shift_nxt = i_rd_data;
              oe_n_nxt = i_rd_data[7];
            end else begin
              state_nxt = ST_RX_BYTE;
              kind_nxt = (kind_r == KIND_CTRL) ? KIND_ADDR : KIND_WDATA;
              oe_n_nxt = 1'b1;
            end
          end
        end
        ST_TX_BYTE: begin
          if (scl_fall) begin
            if (bitcnt_r == TX_LAST_SHIFT) begin
              state_nxt = ST_ACK_SMP;
              oe_n_nxt = 1'b1;
              ptr_nxt = next_ptr(ptr_r);
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_n_nxt = shift_r[6];
              bitcnt_nxt = bitcnt_r + 4'h1;
            end
          end
        end
        ST_ACK_SMP: begin
          if (scl_rise) begin
            mack_nxt = !sda_s;
          end else if (scl_fall) begin
            if (mack_r) begin
              // no byte count kept: reads run as long as the master acks
              state_nxt = ST_TX_BYTE;
              shift_nxt = i_rd_data;
              oe_n_nxt = i_rd_data[7];
              bitcnt_nxt = 4'h0;
            end else begin
              state_nxt = ST_IDLE;
              oe_n_nxt = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      kind_r <= KIND_CTRL;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      read_r <= 1'b0;
      mack_r <= 1'b0;
      ptr_r <= PTR_RESET;
      oe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      read_r <= read_nxt;
      mack_r <= mack_nxt;
      ptr_r <= ptr_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // open-drain: the data value is always low, only the enable moves
  logic sda_out_r;

  always_ff @(posedge i_ref_clk) begin
    sda_out_r <= 1'b0;
  end

  assign o_sda_out = sda_out_r;
  assign o_sda_oe_n = oe_n_r;
  assign o_rd_addr = ptr_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_STOP_RELEASE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    stop_evt |=> o_sda_oe_n && state_r == ST_IDLE)
    else $error("line not released after stop");
  AST_NACK_ENDS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_r == ST_ACK_SMP && scl_fall && !mack_r && !stop_evt && !start_evt)
    |=> state_r == ST_IDLE ##1 o_sda_oe_n)
    else $error("transmission continued after nack");
  AST_RESTART_KEEPS_PTR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_evt |=> ptr_r == $past(ptr_r))
    else $error("pointer changed on repeated start");
  AST_READ_SENDS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state_r == ST_ACK_DRV && scl_fall && kind_r == KIND_CTRL && read_r
     && !stop_evt && !start_evt)
    |=> state_r == ST_TX_BYTE && o_sda_oe_n == $past(i_rd_data[7]))
    else $error("read byte not started after control ack");
  AST_ADV_ONE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ptr_adv && !stop_evt && !start_evt && ptr_r != TK_LAST && ptr_r != RAM_LAST)
    |=> ptr_r == $past(ptr_r) + 7'h01)
    else $error("pointer did not advance by one");
  AST_WRAP_TK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ptr_adv && !stop_evt && !start_evt && ptr_r == TK_LAST) |=> ptr_r == TK_FIRST)
    else $error("timekeeping block did not wrap");
  AST_WRAP_RAM: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ptr_adv && !stop_evt && !start_evt && ptr_r == RAM_LAST) |=> ptr_r == RAM_FIRST)
    else $error("memory block did not wrap");
  AST_PTR_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ptr_r <= RAM_LAST)
    else $error("pointer outside mapped space");
  AST_BACKUP_NO_ACK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (byte_done && i_on_backup && !stop_evt && !start_evt) |=> o_sda_oe_n [*2])
    else $error("acknowledged while on backup supply");
  AST_NINTH_RELEASED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state_r == ST_ACK_SMP |-> o_sda_oe_n)
    else $error("line driven during master ack slot");
endmodule : rtcc_read_target

//--- sim/bus_master_model.sv
module bus_master_model (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // bit timing
  // ------------------------------------------------------------
  // extra low time per phase, lets a scenario act as a slow master
  int slow = 0;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // sample late in the high phase: target answers ~3 clk after a fall
  task automatic bit_cycle(input logic b, output logic r);
    #(20 + slow) o_sda_low = ~b;
    #(20 + slow) o_scl = 1'b1;
    #38 r = i_sda;
    #2 o_scl = 1'b0;
  endtask : bit_cycle

  task automatic start_cond();
    if (!o_scl) begin // repeated start
      #20 o_sda_low = 1'b0;
      #20 o_scl = 1'b1;
    end
    #20 o_sda_low = 1'b1;
    #20 o_scl = 1'b0;
  endtask : start_cond

  // clock left high afterwards: it stands still between frames
  task automatic stop_cond();
    #20 o_sda_low = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda_low = 1'b0;
    #40;
  endtask : stop_cond

  task automatic xfer(input logic [7:0] tx, input logic nbit, output logic [7:0] rx,
                      output logic nin);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(tx[i], rx[i]); // msb first
    end
    bit_cycle(nbit, nin); // ninth clock: ack or withheld ack
  endtask : xfer
endmodule : bus_master_model

//--- sim/testbench.sv
module testbench
  import rtcc_read_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic rst = 1'b1;
  logic backup = 1'b0;
  logic scl;
  logic m_low;
  logic oe_n;
  logic sda_out;
  logic [PTR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic [6:0] exp_ptr = 7'h00;
  wire sda;
  int errors = 0;
  int checks_done = 0;

  // pull-up: wire is low only while someone pulls it
  assign sda = ~m_low & (oe_n | sda_out);

  function automatic logic [7:0] mem(input logic [6:0] a);
    return {1'b0, a} ^ 8'ha5;
  endfunction : mem

  function automatic logic [6:0] exp_next(input logic [6:0] p);
    return (p == 7'h1f) ? 7'h00 : (p == 7'h5f) ? 7'h20 : p + 7'h01;
  endfunction : exp_next

  assign rd_data = mem(rd_addr);

  rtcc_read_target dut_u (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .i_on_backup(backup),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data));
  bus_master_model master_u (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic rand_read(input logic [6:0] a, input int n);
    logic [7:0] rx;
    logic nin;
    logic [6:0] p;
    p = a;
    master_u.start_cond();
    master_u.xfer({DEV_ADDR, RW_WRITE}, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    master_u.xfer({1'b0, a}, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    master_u.start_cond();
    master_u.xfer({DEV_ADDR, RW_READ}, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    for (int i = 0; i < n; i++) begin
      master_u.xfer(8'hff, i == n - 1, rx, nin);
      check(rx, mem(p));
      p = exp_next(p);
    end
    master_u.stop_cond();
    check({7'h00, oe_n}, 8'h01);
    check({1'b0, rd_addr}, {1'b0, p});
    exp_ptr = p;
  endtask : rand_read

  task automatic cur_read();
    logic [7:0] rx;
    logic nin;
    master_u.start_cond();
    master_u.xfer({DEV_ADDR, RW_READ}, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    master_u.xfer(8'hff, 1'b1, rx, nin);
    check(rx, mem(exp_ptr));
    master_u.stop_cond();
    exp_ptr = exp_next(exp_ptr);
    check({1'b0, rd_addr}, {1'b0, exp_ptr});
  endtask : cur_read

  // exp_nak: expected ninth-bit level for control then address byte
  task automatic refused(input logic [7:0] c, input logic [7:0] a, input logic bk,
                         input logic [1:0] exp_nak);
    logic [7:0] rx;
    logic nin;
    @(posedge clk) #1 backup = bk;
    master_u.start_cond();
    master_u.xfer(c, 1'b1, rx, nin);
    check({7'h00, nin}, {7'h00, exp_nak[1]});
    master_u.xfer(a, 1'b1, rx, nin);
    check({7'h00, nin}, {7'h00, exp_nak[0]});
    master_u.stop_cond();
    @(posedge clk) #1 backup = 1'b0;
    check({1'b0, rd_addr}, {1'b0, exp_ptr});
  endtask : refused

  // pointer load followed by one write-data byte, which is acked but not kept
  task automatic wr_addr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    logic nin;
    master_u.start_cond();
    master_u.xfer({DEV_ADDR, RW_WRITE}, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    master_u.xfer({1'b0, a}, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    master_u.xfer(d, 1'b1, rx, nin);
    check({7'h00, nin}, 8'h00);
    master_u.stop_cond();
    check({1'b0, rd_addr}, {1'b0, a});
    exp_ptr = a;
  endtask : wr_addr

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    // keep every bus change clear of the sampling edge
    #1;
    rand_read(7'h10, 1);
    cur_read();
    rand_read(7'h1e, 3);
    master_u.slow = 60;
    rand_read(7'h5e, 3);
    master_u.slow = 0;
    rand_read(7'h20, 65);
    refused({7'h6e, RW_WRITE}, 8'h10, 1'b0, 2'b11);
    refused({DEV_ADDR, RW_WRITE}, 8'h60, 1'b0, 2'b01);
    refused({DEV_ADDR, RW_WRITE}, 8'h10, 1'b1, 2'b11);
    wr_addr(7'h33, 8'h5a);
    cur_read();
    test_done();
  end
endmodule : testbench
